//--- rtl/drf_defines.svh
// Offsets, field positions, reset values and counts of the ring fetch block.
`ifndef DRF_DEFINES_SVH
`define DRF_DEFINES_SVH
`define DRF_ADDR_CTRL      12'h000
`define DRF_ADDR_STATUS    12'h004
`define DRF_ADDR_RING      12'h008
`define DRF_ADDR_PTR       12'h00c
`define DRF_ADDR_CMD       12'h010
`define DRF_ADDR_CMD_EXT   12'h014
`define DRF_ADDR_IND       12'h018
`define DRF_ADDR_DESC_LO   12'h01c
`define DRF_ADDR_DESC_HI   12'h020
`define DRF_ADDR_COUNT     12'h024
`define DRF_CTRL_HPE       0
`define DRF_CTRL_RPE       1
`define DRF_CTRL_DPE       2
`define DRF_ST_RNR         0
`define DRF_ST_RER         1
`define DRF_ST_HER         2
`define DRF_ST_OER         3
`define DRF_ST_PER         4
`define DRF_CMD_READY      8'h01
`define DRF_CMD_STOP       8'h02
`define DRF_CMD_DEFINE     8'h03
`define DRF_DESC_FIRST     62
`define DRF_DESC_LAST      61
`define DRF_DESC_OWN       63
`define DRF_DESC_CMD       60
`define DRF_STORE_DEPTH    20
`define DRF_PER_DATA       3'h2
`define DRF_PER_DESC       3'h7
`define DRF_RESET_CTRL     32'h0000_0000
`endif

//--- rtl/drf_pkg.sv
// Types shared by the ring fetch block.
package drf_pkg;
  typedef enum logic [1:0] {
    drf_ring_stopped,
    drf_ring_ready,
    drf_ring_empty
  } drf_ring_e;
  typedef logic [63:0] drf_desc_t;
endpackage : drf_pkg

//--- rtl/drf_store_if.sv
// Push/pop carrier between the fetch logic and the descriptor store.
`timescale 1ns/10ps
`default_nettype none
interface drf_store_if;
  logic              push;
  drf_pkg::drf_desc_t push_data;
  logic              pop;
  drf_pkg::drf_desc_t pop_data;
  logic              full;
  logic              empty;
  logic              flush;
  logic [4:0]        count;
  modport owner (output push, push_data, pop, flush,
                 input pop_data, full, empty, count);
  modport store (input push, push_data, pop, flush,
                 output pop_data, full, empty, count);
endinterface : drf_store_if
`default_nettype wire

//--- rtl/drf_store.sv
// Internal descriptor copy: holds at most twenty descriptors.
`timescale 1ns/10ps
`default_nettype none
`include "drf_defines.svh"
module drf_store (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // Store side
  drf_store_if.store       st
);
  drf_pkg::drf_desc_t mem [0:`DRF_STORE_DEPTH-1];
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [4:0] cnt;
  wire        do_push = st.push && !st.full;
  wire        do_pop  = st.pop && !st.empty;

  function automatic logic [4:0] bump(input logic [4:0] p);
    bump = (p == 5'(`DRF_STORE_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction : bump

  assign st.full     = (cnt == 5'(`DRF_STORE_DEPTH));
  assign st.empty    = (cnt == 5'h00);
  assign st.count    = cnt;
  assign st.pop_data = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (ce && do_push) begin
      mem[wr_ptr] <= st.push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      cnt    <= 5'h00;
    end else if (ce) begin
      if (st.flush) begin
        wr_ptr <= 5'h00;
        rd_ptr <= 5'h00;
        cnt    <= 5'h00;
      end else begin
        if (do_push) wr_ptr <= bump(wr_ptr);
        if (do_pop) rd_ptr <= bump(rd_ptr);
        cnt <= cnt + 5'(do_push) - 5'(do_pop);
      end
    end
  end
endmodule : drf_store
`default_nettype wire

//--- rtl/drf_tx_parity.sv
// Parity generator toward the transmit side and checker for incoming words.
`timescale 1ns/10ps
`default_nettype none
module drf_tx_parity (
  // Data to protect
  input  wire logic [31:0] data,
  input  wire logic [3:0]  par_in,
  // Results
  output logic [3:0]       par_gen,
  output logic             par_bad
);
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      odd_par[i] = ~^d[i*8 +: 8];
    end
  endfunction : odd_par

  // Generated always, whether or not checking is enabled.
  assign par_gen = odd_par(data);
  assign par_bad = (par_gen != par_in);
endmodule : drf_tx_parity
`default_nettype wire

//--- rtl/drf_fetch.sv
// Descriptor ring fetch, parity checks and error handling behind APB.
// What this block does
// - Copy valid descriptors into internal store, twenty at most; transmit from it.
// - Fetching continues while indication write-back waits on a busy port.
// - Transmit data parity checked only with data parity enable set.
// - Parity is always generated on data sent toward the MAC.
// - Data parity error stops frame intake and marks frame as error.
// - A frame already being sent is aborted on data parity error.
// - Error indication written back unless one is still waiting; ring activity continues normally.
// - Descriptor parity checked only with ring parity enable set.
// - Bad-parity descriptor not stored; read pointer stays on it.
// - Descriptor parity error empties ring, sets ring parity-error bit.
// - Descriptor parity error sets ring-not-ready and ring-error flags.
// - Host register parity checked only with host parity enable set.
// - Bad-parity host access does no clear, command or control access.
// - Host parity error sets the host-error flag.
// - Bad-parity write to command extension cancels the command.
// - First/last framing errors stop fetch, empty ring, set error flags.
// - DMA indication carries abort flag and three-bit error code.
`timescale 1ns/10ps
`default_nettype none
`include "drf_defines.svh"
module drf_fetch (
  // Clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host parity lines beside pwdata
  input  wire logic [3:0]  pwpar,
  // Descriptor read port toward ring memory
  output logic             desc_req,
  output logic [31:0]      desc_addr,
  input  wire logic        desc_valid,
  input  wire logic [63:0] desc_data,
  input  wire logic [7:0]  desc_par,
  // Transmit data port
  input  wire logic        txd_valid,
  input  wire logic [31:0] txd_data,
  input  wire logic [3:0]  txd_par,
  input  wire logic        txd_last,
  // Toward MAC side
  output logic             mac_valid,
  output logic [31:0]      mac_data,
  output logic [3:0]       mac_par,
  output logic             mac_abort,
  input  wire logic        mac_sending,
  // Descriptor consumer
  input  wire logic        desc_take,
  output logic [63:0]      desc_out,
  output logic             desc_avail,
  // Indication write-back port
  output logic             ind_valid,
  output logic [31:0]      ind_data,
  input  wire logic        ind_ready
);
  // Descriptor, transmit, MAC and indication inputs are synchronised; only the second stage is read.
  logic       dv_s1, dv_s2, tv_s1, tv_s2, ms_s1, ms_s2, ir_s1, ir_s2;
  logic [63:0] dd_s1, dd_s2;
  logic [7:0]  dp_s1, dp_s2;
  logic [31:0] td_s1, td_s2;
  logic [3:0]  tp_s1, tp_s2;
  logic        tl_s1, tl_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dv_s1, dv_s2, tv_s1, tv_s2} <= 4'h0;
      {ms_s1, ms_s2, ir_s1, ir_s2} <= 4'h0;
      {tl_s1, tl_s2} <= 2'h0;
      dd_s1 <= 64'h0; dd_s2 <= 64'h0;
      dp_s1 <= 8'h00; dp_s2 <= 8'h00;
      td_s1 <= 32'h0; td_s2 <= 32'h0;
      tp_s1 <= 4'h0;  tp_s2 <= 4'h0;
    end else if (ce) begin
      dv_s1 <= desc_valid;  dv_s2 <= dv_s1;
      tv_s1 <= txd_valid;   tv_s2 <= tv_s1;
      ms_s1 <= mac_sending; ms_s2 <= ms_s1;
      ir_s1 <= ind_ready;   ir_s2 <= ir_s1;
      tl_s1 <= txd_last;    tl_s2 <= tl_s1;
      dd_s1 <= desc_data;   dd_s2 <= dd_s1;
      dp_s1 <= desc_par;    dp_s2 <= dp_s1;
      td_s1 <= txd_data;    td_s2 <= td_s1;
      tp_s1 <= txd_par;     tp_s2 <= tp_s1;
    end
  end

  // Registers.
  logic [31:0] ctrl;
  logic [4:0]  status;
  logic [31:0] ring_base;
  logic [31:0] rd_ptr;
  logic [7:0]  cmd_held;
  logic        cmd_ext_bad;
  logic [63:0] ind_shadow;
  drf_pkg::drf_ring_e ring_state;
  logic        last_expected;
  logic        frame_err;
  logic        req_pend;

  // APB decode: single wait-free access phase.
  wire wr_en  = psel && penable && pwrite;
  wire rd_en  = psel && penable && !pwrite;
  wire mapped = (paddr <= `DRF_ADDR_COUNT) && (paddr[1:0] == 2'b00);
  wire host_chk = ctrl[`DRF_CTRL_HPE];
  wire [3:0] hp_gen;
  wire       hp_bad_raw;
  drf_tx_parity u_host_par (
    .data    (pwdata),
    .par_in  (pwpar),
    .par_gen (hp_gen),
    .par_bad (hp_bad_raw)
  );
  wire host_bad = wr_en && mapped && host_chk && hp_bad_raw;
  wire wr_ok    = wr_en && mapped && !host_bad;
  wire wr_status = wr_ok && (paddr == `DRF_ADDR_STATUS);
  wire wr_cmd    = wr_ok && (paddr == `DRF_ADDR_CMD);
  wire wr_cext   = wr_en && mapped && (paddr == `DRF_ADDR_CMD_EXT);
  wire cmd_go    = wr_cmd && !cmd_ext_bad;
  wire cmd_ready = cmd_go && (pwdata[7:0] == `DRF_CMD_READY);
  wire cmd_stop  = cmd_go && (pwdata[7:0] == `DRF_CMD_STOP);
  wire cmd_def   = cmd_go && (pwdata[7:0] == `DRF_CMD_DEFINE);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Descriptor fetch: one read in flight at a time.
  drf_store_if st ();
  drf_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .st      (st)
  );

  function automatic logic par_ok64(input logic [63:0] d,
                                    input logic [7:0] p);
    par_ok64 = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (p[i] != ~^d[i*8 +: 8]) par_ok64 = 1'b0;
    end
  endfunction : par_ok64

  wire got_desc  = req_pend && dv_s2;
  wire d_par_err = got_desc && ctrl[`DRF_CTRL_RPE] &&
                   !par_ok64(dd_s2, dp_s2);
  wire d_own     = dd_s2[`DRF_DESC_OWN];
  wire d_first   = dd_s2[`DRF_DESC_FIRST];
  wire d_last    = dd_s2[`DRF_DESC_LAST];
  wire d_cmd     = dd_s2[`DRF_DESC_CMD];
  // Framing checks of the three documented kinds.
  wire d_frm_err = got_desc && d_own && !d_par_err &&
                   ((d_first && last_expected) ||
                    (!d_first && !last_expected) ||
                    (d_cmd && !d_last));
  wire d_invalid = got_desc && !d_own && !d_par_err;
  wire d_store   = got_desc && d_own && !d_par_err && !d_frm_err;
  wire d_error   = d_par_err || d_frm_err;

  // Fetch runs regardless of indication back-pressure.
  assign desc_req  = req_pend;
  assign desc_addr = rd_ptr;
  assign st.push      = d_store;
  assign st.push_data = dd_s2;
  assign st.pop       = desc_take && !st.empty;
  assign st.flush     = cmd_stop || cmd_def || d_error;
  assign desc_out     = st.pop_data;
  assign desc_avail   = !st.empty;

  wire can_fetch = (ring_state == drf_pkg::drf_ring_ready) &&
                   !st.full && !req_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_pend      <= 1'b0;
      rd_ptr        <= 32'h0;
      ring_state    <= drf_pkg::drf_ring_stopped;
      last_expected <= 1'b0;
    end else if (ce) begin
      if (cmd_def) begin
        rd_ptr        <= ring_base;
        ring_state    <= drf_pkg::drf_ring_stopped;
        last_expected <= 1'b0;
        req_pend      <= 1'b0;
      end else if (cmd_stop) begin
        ring_state <= drf_pkg::drf_ring_stopped;
        req_pend   <= 1'b0;
      end else if (cmd_ready) begin
        ring_state <= drf_pkg::drf_ring_ready;
      end else if (d_error) begin
        // The pointer is left on the bad entry for the host to find.
        req_pend   <= 1'b0;
        ring_state <= drf_pkg::drf_ring_empty;
      end else if (d_invalid) begin
        req_pend   <= 1'b0;
        ring_state <= drf_pkg::drf_ring_empty;
      end else if (d_store) begin
        req_pend      <= 1'b0;
        rd_ptr        <= rd_ptr + 32'h8;
        last_expected <= !d_last;
      end else if (can_fetch) begin
        req_pend <= 1'b1;
      end
    end
  end

  // Status flags: hardware set wins over a write-one clear.
  wire [4:0] st_set = {d_par_err, d_frm_err, host_bad,
                       d_error, d_error};
  wire [4:0] st_clr = wr_status ? pwdata[4:0] : 5'h00;
  wire [4:0] next_status;
  assign next_status = (status & ~st_clr) | st_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 5'h00;
    end else if (ce) begin
      status <= next_status;
      if (cmd_ready || cmd_def) begin
        status[`DRF_ST_PER] <= st_set[`DRF_ST_PER];
        status[`DRF_ST_OER] <= st_set[`DRF_ST_OER];
      end
    end
  end

  // Command extension parity: a bad write cancels the next command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ext_bad <= 1'b0;
      cmd_held    <= 8'h00;
      ctrl        <= `DRF_RESET_CTRL;
      ring_base   <= 32'h0;
    end else if (ce) begin
      if (wr_cext) cmd_ext_bad <= host_bad;
      else if (wr_cmd) cmd_ext_bad <= 1'b0;
      if (wr_cmd) cmd_held <= pwdata[7:0];
      if (wr_ok && paddr == `DRF_ADDR_CTRL) ctrl <= pwdata;
      if (wr_ok && paddr == `DRF_ADDR_RING) ring_base <= pwdata;
    end
  end

  // Transmit data path with optional parity check.
  wire [3:0] tx_gen;
  wire       tx_bad_raw;
  drf_tx_parity u_tx_par (
    .data    (td_s2),
    .par_in  (tp_s2),
    .par_gen (tx_gen),
    .par_bad (tx_bad_raw)
  );
  wire tx_perr = tv_s2 && ctrl[`DRF_CTRL_DPE] && tx_bad_raw;
  wire frame_end = tv_s2 && tl_s2;
  wire ind_busy  = ind_valid && !ir_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_err  <= 1'b0;
      mac_valid  <= 1'b0;
      mac_data   <= 32'h0;
      mac_par    <= 4'h0;
      mac_abort  <= 1'b0;
      ind_valid  <= 1'b0;
      ind_data   <= 32'h0;
      ind_shadow <= 64'h0;
    end else if (ce) begin
      // Data stops flowing for the rest of an error frame.
      mac_valid <= tv_s2 && !tx_perr && !frame_err;
      mac_data  <= td_s2;
      mac_par   <= tx_gen;
      mac_abort <= tx_perr && ms_s2 && !frame_err;
      if (tx_perr) frame_err <= !frame_end;
      else if (frame_end) frame_err <= 1'b0;
      if (ind_valid && ir_s2) ind_valid <= 1'b0;
      // Indication per frame unless one is still waiting; fetch is not held while it waits.
      if (frame_end && !ind_busy) begin
        ind_valid <= 1'b1;
        ind_data  <= {(frame_err || tx_perr), 25'h0,
                      ((frame_err || tx_perr) ? `DRF_PER_DATA : 3'h0),
                      3'h0};
      end
      if (d_par_err) ind_shadow <= {1'b1, `DRF_PER_DESC, 60'h0};
    end
  end

  // Read mux.
  wire [31:0] rd_mux =
    (paddr == `DRF_ADDR_CTRL)    ? ctrl :
    (paddr == `DRF_ADDR_STATUS)  ? {27'h0, status} :
    (paddr == `DRF_ADDR_RING)    ? ring_base :
    (paddr == `DRF_ADDR_PTR)     ? rd_ptr :
    (paddr == `DRF_ADDR_CMD)     ? {22'h0, ring_state, cmd_held} :
    (paddr == `DRF_ADDR_IND)     ? ind_shadow[63:32] :
    (paddr == `DRF_ADDR_DESC_LO) ? st.pop_data[31:0] :
    (paddr == `DRF_ADDR_DESC_HI) ? st.pop_data[63:32] :
    (paddr == `DRF_ADDR_COUNT)   ? {27'h0, st.count} : 32'h0;
  assign prdata = rd_en ? rd_mux : 32'h0;
endmodule : drf_fetch
`default_nettype wire

//--- verification/drf_ring_mem.sv
// Ring memory model that answers descriptor reads.
`timescale 1ns/10ps
`default_nettype none
module drf_ring_mem (
  // Clock
  input  wire logic        pclk,
  // Descriptor read port
  input  wire logic        desc_req,
  input  wire logic [31:0] desc_addr,
  output logic             desc_valid,
  output logic [63:0]      desc_data,
  output logic [7:0]       desc_par
);
  logic [63:0] mem [0:31];
  int          bad_idx = -1;
  int          lag     = 1;
  int          k;
  initial begin
    desc_valid = 1'b0;
    desc_data  = 64'h0;
    desc_par   = 8'h0;
    forever begin
      @(posedge pclk);
      if (desc_req === 1'b1) begin
        k = int'(desc_addr[7:3]);
        repeat (lag) @(posedge pclk);
        desc_valid <= 1'b1;
        desc_data  <= mem[k];
        for (int b = 0; b < 8; b++)
          desc_par[b] <= ~^mem[k][8*b+:8] ^ (b == 0 && k == bad_idx);
        @(posedge pclk);
        // Released lines show the inverse so stale data cannot pass.
        desc_valid <= 1'b0;
        desc_data  <= ~mem[k];
        desc_par   <= ~desc_par;
        repeat (5) @(posedge pclk);
      end
    end
  end
endmodule : drf_ring_mem
`default_nettype wire

//--- verification/drf_fetch_chk.sv
// Port-level assertions for the descriptor ring fetch block.
`timescale 1ns/10ps
`default_nettype none
`include "drf_defines.svh"
module drf_fetch_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Descriptor and MAC sides
  input wire logic        desc_req,
  input wire logic [31:0] desc_addr,
  input wire logic        mac_valid,
  input wire logic [31:0] mac_data,
  input wire logic [3:0]  mac_par,
  input wire logic        mac_abort,
  // Indication port
  input wire logic        ind_valid,
  input wire logic [31:0] ind_data,
  input wire logic        ind_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic       rd_acc  = psel && penable && !pwrite;
  wire logic [3:0] gen_par = {~^mac_data[31:24], ~^mac_data[23:16],
                              ~^mac_data[15:8], ~^mac_data[7:0]};
  property p_par_gen; mac_valid |-> mac_par == gen_par; endproperty
  a_par_gen: assert property (p_par_gen)
    else $error("mac parity is not odd per byte");
  property p_req_hold; $rose(desc_req) |=> desc_req [*2]; endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("descriptor request dropped early");
  property p_addr_hold; $rose(desc_req) |=> $stable(desc_addr) [*2];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("descriptor address moved during a read");
  property p_addr_align; desc_req |-> desc_addr[2:0] == 3'h0; endproperty
  a_addr_align: assert property (p_addr_align)
    else $error("read pointer not on a descriptor start");
  property p_count_max;
    rd_acc && paddr == `DRF_ADDR_COUNT |-> prdata <= `DRF_STORE_DEPTH;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("store holds more than twenty descriptors");
  property p_ptr_read;
    rd_acc && paddr == `DRF_ADDR_PTR |-> prdata == desc_addr;
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("read pointer register differs from fetch address");
  property p_ind_hold;
    ind_valid && !ind_ready && !$past(ind_ready) && !$past(ind_ready, 2)
      && !$past(ind_ready, 3) |=> ind_valid && $stable(ind_data);
  endproperty
  a_ind_hold: assert property (p_ind_hold)
    else $error("indication dropped before it was accepted");
  property p_ind_code;
    $rose(ind_valid) && ind_data[31] |-> ind_data[5:3] == `DRF_PER_DATA;
  endproperty
  a_ind_code: assert property (p_ind_code)
    else $error("aborted transfer carries wrong error code");
  property p_abort_pulse; mac_abort |=> !mac_abort; endproperty
  a_abort_pulse: assert property (p_abort_pulse)
    else $error("abort toward the MAC is longer than one cycle");
  c_fetch: cover property ($fell(desc_req));
  c_abort: cover property (mac_abort);
  c_ind: cover property (ind_valid && ind_ready);
endmodule : drf_fetch_chk
bind drf_fetch drf_fetch_chk drf_fetch_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .desc_req(desc_req),
  .desc_addr(desc_addr), .mac_valid(mac_valid), .mac_data(mac_data),
  .mac_par(mac_par), .mac_abort(mac_abort), .ind_valid(ind_valid),
  .ind_data(ind_data), .ind_ready(ind_ready));
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the descriptor ring fetch block.
`timescale 1ns/10ps
`default_nettype none
`include "drf_defines.svh"
module testbench;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        desc_req, desc_valid, desc_take, desc_avail, err;
  logic        txd_valid, txd_last, mac_valid, mac_abort, mac_sending;
  logic        ind_valid, ind_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, desc_addr, txd_data, mac_data, ind_data;
  logic [31:0] rd, ind_last;
  logic [3:0]  pwpar, txd_par, mac_par;
  logic [63:0] desc_data, desc_out;
  logic [7:0]  desc_par;
  logic [35:0] mac_q[$], exp_q[$];
  int          num_errors, tests_run, abort_n, n0, seed;
  localparam logic [31:0] RF = (32'h1 << `DRF_ST_RNR)
                              | (32'h1 << `DRF_ST_RER);
  localparam logic [31:0] EMP = 32'(drf_pkg::drf_ring_empty) << 8;
  localparam logic [31:0] STP = 32'(drf_pkg::drf_ring_stopped) << 8;
  localparam logic [11:0] RA [5] = '{`DRF_ADDR_CTRL, `DRF_ADDR_STATUS,
    `DRF_ADDR_PTR, `DRF_ADDR_CMD, `DRF_ADDR_COUNT};
  drf_fetch drf_fetch_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwpar(pwpar), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_par(desc_par), .txd_valid(txd_valid),
    .txd_data(txd_data), .txd_par(txd_par), .txd_last(txd_last),
    .mac_valid(mac_valid), .mac_data(mac_data), .mac_par(mac_par),
    .mac_abort(mac_abort), .mac_sending(mac_sending),
    .desc_take(desc_take), .desc_out(desc_out), .desc_avail(desc_avail),
    .ind_valid(ind_valid), .ind_data(ind_data), .ind_ready(ind_ready));
  drf_ring_mem drf_ring_mem_i (.pclk(pclk), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_par(desc_par));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mac_valid === 1'b1) mac_q.push_back({mac_par, mac_data});
    if (mac_abort === 1'b1) abort_n++;
    if ((ind_valid & ind_ready) === 1'b1) ind_last = ind_data;
  end
  function automatic logic [3:0] par(input logic [31:0] d);
    for (int b = 0; b < 4; b++) par[b] = ~^d[8*b+:8];
  endfunction : par
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] p);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pwpar   <= p;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      chk(pready, 1'b1);
      report_and_stop();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] f = 4'h0);
    apb(1'b1, a, d, par(d) ^ f);
  endtask : wr
  // Polls up to the given count; with more than one try, a read that never matches ends the run.
  task automatic rdw(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e, input int tries);
    for (int n = 0; n < tries; n++) begin
      apb(1'b0, a, 32'h0, par(32'h0));
      if ((rd & m) === e) break;
    end
    chk(rd & m, e);
    if ((rd & m) !== e && tries > 1) report_and_stop();
  endtask : rdw
  task automatic drain(input int s, input int n);
    int k;
    for (int i = s; i < s + n; i++) begin
      for (k = 0; k < 300; k++) begin
        @(posedge pclk);
        if (desc_avail === 1'b1) break;
      end
      chk(desc_out, drf_ring_mem_i.mem[i]);
      if (k == 300) report_and_stop();
      desc_take <= 1'b1;
      @(posedge pclk);
      desc_take <= 1'b0;
    end
  endtask : drain
  task automatic send(input int n, input int badw, input bit chkp);
    logic [31:0] d;
    for (int w = 0; w < n; w++) begin
      @(posedge pclk);
      d = $random(seed);
      txd_valid <= 1'b1;
      txd_data  <= d;
      txd_par   <= par(d) ^ {3'h0, w == badw};
      txd_last  <= (w == n - 1);
      if (!chkp || w < badw) exp_q.push_back({par(d), d});
    end
    @(posedge pclk);
    txd_valid <= 1'b0;
    txd_last  <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(mac_q.size(), exp_q.size());
    while (exp_q.size() > 0 && mac_q.size() > 0)
      chk(mac_q.pop_front(), exp_q.pop_front());
    mac_q.delete();
    exp_q.delete();
  endtask : send
  initial begin
    {presetn, psel, penable, pwrite, desc_take, txd_valid} = 6'h0;
    {txd_last, mac_sending, ind_ready} = 3'h0;
    {paddr, pwdata, pwpar, txd_data, txd_par} = 84'h0;
    ce = 1'b1;
    {num_errors, tests_run, abort_n, n0} = '0;
    seed = 32'hb66f;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdw(RA[i], '1, 32'h0, 1);
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    chk(err, 1'b1);
    $display("test reset done");
    send(3, 1, 1'b0);
    chk(ind_valid, 1'b1);
    chk(ind_data & 32'h8000_0038, 32'h0);
    $display("test unchecked data done");
    for (int i = 0; i < 32; i++)
      drf_ring_mem_i.mem[i] = (i < 25) ? {4'he, 28'($random(seed)),
        32'($random(seed))} : 64'h0;
    drf_ring_mem_i.bad_idx = 2;
    wr(`DRF_ADDR_RING, 32'h0);
    wr(`DRF_ADDR_CMD, `DRF_CMD_DEFINE);
    wr(`DRF_ADDR_CMD, `DRF_CMD_READY);
    rdw(`DRF_ADDR_COUNT, '1, `DRF_STORE_DEPTH, 300);
    rdw(`DRF_ADDR_STATUS, '1, 32'h0, 1);
    chk(ind_valid, 1'b1);
    rdw(`DRF_ADDR_DESC_HI, '1, drf_ring_mem_i.mem[0][63:32], 1);
    drain(0, 25);
    rdw(`DRF_ADDR_CMD, 32'h300, EMP, 50);
    rdw(`DRF_ADDR_PTR, '1, 32'd200, 1);
    ind_ready <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(ind_valid, 1'b0);
    $display("test fill done");
    wr(`DRF_ADDR_CTRL, 32'h1 << `DRF_CTRL_DPE);
    mac_sending <= 1'b1;
    n0 = abort_n;
    send(3, 1, 1'b1);
    chk(abort_n - n0, 1);
    chk(ind_last & 32'h8000_0038,
        32'h8000_0000 | (32'(`DRF_PER_DATA) << 3));
    mac_sending <= 1'b0;
    $display("test data parity done");
    wr(`DRF_ADDR_CTRL, 32'h1 << `DRF_CTRL_RPE);
    drf_ring_mem_i.lag = 4;
    wr(`DRF_ADDR_CMD, `DRF_CMD_DEFINE);
    wr(`DRF_ADDR_CMD, `DRF_CMD_READY);
    rdw(`DRF_ADDR_STATUS, '1, RF | (32'h1 << `DRF_ST_PER), 300);
    rdw(`DRF_ADDR_PTR, '1, 32'd16, 1);
    rdw(`DRF_ADDR_CMD, 32'h300, EMP, 1);
    rdw(`DRF_ADDR_IND, 32'hf000_0000, 32'h8000_0000
        | (32'(`DRF_PER_DESC) << 28), 1);
    drf_ring_mem_i.bad_idx = -1;
    wr(`DRF_ADDR_STATUS, 32'h1f);
    rdw(`DRF_ADDR_STATUS, '1, 32'h0, 1);
    wr(`DRF_ADDR_CMD, `DRF_CMD_READY);
    drain(2, 23);
    $display("test descriptor parity done");
    wr(`DRF_ADDR_CMD, `DRF_CMD_STOP);
    rdw(`DRF_ADDR_CMD, 32'h300, STP, 1);
    drf_ring_mem_i.mem[1][`DRF_DESC_FIRST] = 1'b0;
    wr(`DRF_ADDR_CMD, `DRF_CMD_DEFINE);
    wr(`DRF_ADDR_CMD, `DRF_CMD_READY);
    rdw(`DRF_ADDR_STATUS, '1, RF | (32'h1 << `DRF_ST_OER), 300);
    rdw(`DRF_ADDR_PTR, '1, 32'd8, 1);
    rdw(`DRF_ADDR_CMD, 32'h300, EMP, 1);
    $display("test framing done");
    wr(`DRF_ADDR_CTRL, 32'h1 << `DRF_CTRL_HPE);
    wr(`DRF_ADDR_STATUS, 32'h1f, 4'h1);
    rdw(`DRF_ADDR_STATUS, '1, RF | (32'h1 << `DRF_ST_OER)
        | (32'h1 << `DRF_ST_HER), 1);
    wr(`DRF_ADDR_CMD_EXT, 32'h0, 4'h1);
    wr(`DRF_ADDR_CMD, `DRF_CMD_DEFINE);
    rdw(`DRF_ADDR_CMD, 32'h300, EMP, 1);
    wr(`DRF_ADDR_CTRL, 32'h0);
    wr(`DRF_ADDR_STATUS, 32'h1f, 4'h1);
    rdw(`DRF_ADDR_STATUS, '1, 32'h0, 1);
    $display("test host parity done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
